// ==== design/tms_timing_mode_selector.sv ====
// mode selection, reference tracking, holdover history and hf clock outputs
`timescale 1ns/1ns
// Function
// RQ1 - select code 000 free-run, 001..101 lock ref1..5, 110 ignored, 111 holdover
// RQ2 - free-run drives outputs from the local nominal tuning word only
// RQ3 - holdover drives outputs from the stored history word; until a history word has been stored the code uses the nominal word
// RQ4 - history updates only while locked to a reference
// RQ5 - locked modes step through evaluation, frequency acquisition, then phase locking
// RQ6 - each locked code tracks exactly its own one of five references
// RQ7 - every reference input is monitored continuously regardless of mode
// RQ8 - primary and secondary copy the synthesizer, divided output is derived from it
// RQ9 - divided output divides the primary frequency by 1, 2, 4 or 8
// RQ10 - each output has its own enable input from the host
// RQ11 - select inputs are synchronized and must be stable before acting
module tms_timing_mode_selector #(
   parameter int ACC_W      = 32,
   parameter int CNT_W      = 13,
   parameter int ACQ_STEP   = 32'h0010_0000,
   parameter int PHASE_STEP = 32'h0000_1000,
   parameter int HIST_SHIFT = 4
)(
   input  wire logic                   clk,
   input  wire logic                   sys_rst,
   input  wire logic                   ce,
   input  wire tms_pkg::tms_axi_req_t  axiReq,
   output tms_pkg::tms_axi_rsp_t       axiRsp,
   input  wire logic                   modeSelectBit0,
   input  wire logic                   modeSelectBit1,
   input  wire logic                   modeSelectBit2,
   input  wire logic                   referenceInput1,
   input  wire logic                   referenceInput2,
   input  wire logic                   referenceInput3,
   input  wire logic                   referenceInput4,
   input  wire logic                   referenceInput5,
   input  wire logic                   primaryOutputEnable,
   input  wire logic                   secondaryOutputEnable,
   input  wire logic                   dividedOutputEnable,
   output logic                        hfClockPrimary,
   output logic                        hfClockSecondary,
   output logic                        hfClockDivided
);
   import tms_pkg::*;

   logic [4:0]       refPins;
   logic [4:0]       refEdge;
   logic [4:0]       refValid;
   logic [CNT_W-1:0] refPeriod [5];

   logic [2:0]       selS1;
   logic [2:0]       selS2;
   logic [2:0]       selPrev;
   logic [2:0]       stableCnt;
   logic [2:0]       activeMode;
   logic             modeNew;

   tms_phase_t       phase;
   logic [CNT_W-1:0] timer;
   logic [3:0]       lockCnt;
   logic [CNT_W-1:0] refCnt;
   logic [CNT_W-1:0] ncoCnt;

   logic [ACC_W-1:0] acc;
   logic [ACC_W-1:0] tune;
   logic [ACC_W-1:0] history;
   logic [ACC_W-1:0] histDiff;
   logic             histValid;
   logic             ncoPrev;
   logic [2:0]       divCnt;
   logic             divOut;
   logic [2:0]       enS1;
   logic [2:0]       enS2;

   logic [1:0]       divSel;
   logic [1:0]       divAct;
   logic [31:0]      nominal;

   logic             awHave;
   logic             wHave;
   logic [AXI_ADDR_W-1:0] awAddr;
   logic [31:0]      wData;
   logic [3:0]       wStrb;

   logic             isLockMode;
   logic [2:0]       selIdx;
   logic             selEdge;
   logic             selValid;
   logic             ncoRise;
   logic             phaseSmall;
   logic             acqDone;

   assign refPins = {referenceInput5, referenceInput4, referenceInput3, referenceInput2, referenceInput1};

   // one monitor per reference, independent of the active mode
   for (genvar i = 0; i < 5; i++) begin : g_mon
      tms_ref_monitor #(
         .CNT_W   (CNT_W),
         .TIMEOUT (REF_TIMEOUT_CYCLES),
         .MIN_PER (REF_MIN_PERIOD)
      ) u_mon (
         .clk       (clk),
         .sys_rst   (sys_rst),
         .ce        (ce),
         .refIn     (refPins[i]),
         .refEdge   (refEdge[i]),
         .refValid  (refValid[i]),
         .refPeriod (refPeriod[i])
      ); // RQ7
   end

   // select pin synchronizer
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         selS1 <= MODE_FREE;
         selS2 <= MODE_FREE;
      end else if (ce) begin
         selS1 <= {modeSelectBit2, modeSelectBit1, modeSelectBit0}; // RQ1
         selS2 <= selS1; // RQ11
      end
   end

   // code must hold for several samples; code 110 leaves the mode as is
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         selPrev    <= MODE_FREE;
         stableCnt  <= '0;
         activeMode <= MODE_FREE;
         modeNew    <= 1'b0;
      end else if (ce) begin
         modeNew <= 1'b0;
         if (selS2 != selPrev) begin
            selPrev   <= selS2;
            stableCnt <= '0; // RQ11
         end else if (stableCnt != 3'(MODE_STABLE_SAMPLES - 1)) begin
            stableCnt <= stableCnt + 1'b1;
         end else if (selPrev != MODE_IGNORED && selPrev != activeMode) begin
            activeMode <= selPrev; // RQ1
            modeNew    <= 1'b1;
         end
      end
   end

   assign isLockMode = (activeMode >= MODE_REF1) && (activeMode <= MODE_REF5);
   assign selIdx     = activeMode - MODE_REF1;
   assign selEdge    = isLockMode && refEdge[selIdx]; // RQ6
   assign selValid   = isLockMode && refValid[selIdx]; // RQ6
   assign ncoRise    = acc[ACC_W-1] & ~ncoPrev;
   assign phaseSmall = (acc[ACC_W-1 -: 4] == 4'h0) || (acc[ACC_W-1 -: 4] == 4'hf);
   assign acqDone    = (phase == PH_ACQ) && (timer == CNT_W'(ACQ_CYCLES - 1));

   // lock sequence
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         phase   <= PH_IDLE;
         timer   <= '0;
         lockCnt <= '0;
         refCnt  <= '0;
         ncoCnt  <= '0;
      end else if (ce) begin
         if (modeNew) begin
            phase   <= isLockMode ? PH_EVAL : PH_IDLE; // RQ5
            timer   <= '0;
            lockCnt <= '0;
         end else begin
            unique case (phase)
               PH_IDLE: begin
                  timer <= '0;
               end
               PH_EVAL: begin
                  if (!selValid) begin
                     timer <= '0;
                  end else if (timer == CNT_W'(EVAL_CYCLES - 1)) begin
                     phase  <= PH_ACQ; // RQ5
                     timer  <= '0;
                     refCnt <= '0;
                     ncoCnt <= '0;
                  end else begin
                     timer <= timer + 1'b1;
                  end
               end
               PH_ACQ: begin
                  if (!selValid) begin
                     phase <= PH_EVAL;
                     timer <= '0;
                  end else if (acqDone) begin
                     timer  <= '0;
                     refCnt <= '0;
                     ncoCnt <= '0;
                     if (refCnt == ncoCnt) begin
                        phase   <= PH_PHASE; // RQ5
                        lockCnt <= '0;
                     end
                  end else begin
                     timer  <= timer + 1'b1;
                     refCnt <= refCnt + CNT_W'(selEdge);
                     ncoCnt <= ncoCnt + CNT_W'(ncoRise);
                  end
               end
               PH_PHASE, PH_LOCKED: begin
                  if (!selValid) begin
                     phase <= PH_EVAL;
                     timer <= '0;
                  end else if (selEdge) begin
                     if (!phaseSmall) begin
                        lockCnt <= '0;
                        phase   <= PH_PHASE;
                     end else if (lockCnt == 4'(LOCK_EDGES - 1)) begin
                        phase <= PH_LOCKED;
                     end else begin
                        lockCnt <= lockCnt + 1'b1;
                     end
                  end
               end
            endcase
         end
      end
   end

   // tuning word of the synthesizer
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         tune <= NOMINAL_TUNE_RST;
      end else if (ce) begin
         if (activeMode == MODE_FREE) begin
            tune <= nominal; // RQ2
         end else if (activeMode == MODE_HOLD) begin
            tune <= histValid ? history : nominal; // RQ3
         end else if (acqDone && selValid) begin
            if (ncoCnt > refCnt) begin
               tune <= tune - ACC_W'(ACQ_STEP);
            end else if (ncoCnt < refCnt) begin
               tune <= tune + ACC_W'(ACQ_STEP);
            end
         end else if ((phase == PH_PHASE || phase == PH_LOCKED) && selEdge) begin
            // ahead when the accumulator sits just past wrap at the reference edge
            if (!acc[ACC_W-1]) begin
               tune <= tune - ACC_W'(PHASE_STEP);
            end else begin
               tune <= tune + ACC_W'(PHASE_STEP);
            end
         end
      end
   end

   assign histDiff = tune - history;

   // history averages the tuning word, only while locked
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         history   <= '0;
         histValid <= 1'b0;
      end else if (ce) begin
         if (phase == PH_LOCKED && selEdge) begin
            histValid <= 1'b1; // RQ4
            if (!histValid) begin
               history <= tune;
            end else begin
               history <= history + ACC_W'($signed(histDiff) >>> HIST_SHIFT); // RQ4
            end
         end
      end
   end

   // synthesizer and output stage
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         acc     <= '0;
         ncoPrev <= 1'b0;
         divCnt  <= '0;
         divAct  <= CTRL_DIV_RST;
      end else if (ce) begin
         acc     <= acc + tune;
         ncoPrev <= acc[ACC_W-1];
         if (ncoRise) begin
            divCnt <= divCnt + 1'b1;
            // ratio switches on a synthesizer edge only, no runt pulse
            divAct <= divSel; // RQ9
         end
      end
   end

   always_comb begin
      unique case (divAct)
         2'h0: divOut = ncoPrev; // RQ9
         2'h1: divOut = divCnt[0];
         2'h2: divOut = divCnt[1];
         2'h3: divOut = divCnt[2];
      endcase
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         enS1             <= '0;
         enS2             <= '0;
         hfClockPrimary   <= 1'b0;
         hfClockSecondary <= 1'b0;
         hfClockDivided   <= 1'b0;
      end else if (ce) begin
         enS1             <= {dividedOutputEnable, secondaryOutputEnable, primaryOutputEnable};
         enS2             <= enS1;
         hfClockPrimary   <= ncoPrev & enS2[0]; // RQ8 RQ10
         hfClockSecondary <= ncoPrev & enS2[1]; // RQ8 RQ10
         hfClockDivided   <= divOut & enS2[2]; // RQ8 RQ10
      end
   end

   // register slave
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         axiRsp  <= '0;
         awHave  <= 1'b0;
         wHave   <= 1'b0;
         awAddr  <= '0;
         wData   <= '0;
         wStrb   <= '0;
         divSel  <= CTRL_DIV_RST;
         nominal <= NOMINAL_TUNE_RST;
      end else if (ce) begin
         axiRsp.awready <= !awHave && !(axiReq.awvalid && axiRsp.awready) && !axiRsp.bvalid;
         axiRsp.wready  <= !wHave && !(axiReq.wvalid && axiRsp.wready) && !axiRsp.bvalid;
         if (axiReq.awvalid && axiRsp.awready) begin
            awHave <= 1'b1;
            awAddr <= axiReq.awaddr;
         end
         if (axiReq.wvalid && axiRsp.wready) begin
            wHave <= 1'b1;
            wData <= axiReq.wdata;
            wStrb <= axiReq.wstrb;
         end
         if (awHave && wHave && !axiRsp.bvalid) begin
            awHave         <= 1'b0;
            wHave          <= 1'b0;
            axiRsp.bvalid  <= 1'b1;
            axiRsp.bresp   <= RESP_OKAY;
            unique case (awAddr)
               REG_CTRL: begin
                  if (wStrb[0]) begin
                     divSel <= wData[CTRL_DIV_LSB +: 2];
                  end
               end
               REG_NOMINAL: begin
                  for (int b = 0; b < 4; b++) begin
                     if (wStrb[b]) begin
                        nominal[8*b +: 8] <= wData[8*b +: 8];
                     end
                  end
               end
               REG_STATUS, REG_TUNE, REG_HISTORY: ;
               default: axiRsp.bresp <= RESP_SLVERR;
            endcase
         end else if (axiRsp.bvalid && axiReq.bready) begin
            axiRsp.bvalid <= 1'b0;
         end
         if (axiReq.arvalid && axiRsp.arready) begin
            axiRsp.arready <= 1'b0;
            axiRsp.rvalid  <= 1'b1;
            axiRsp.rresp   <= RESP_OKAY;
            axiRsp.rdata   <= '0;
            unique case (axiReq.araddr)
               REG_CTRL:    axiRsp.rdata[CTRL_DIV_LSB +: 2] <= divSel;
               REG_STATUS: begin
                  axiRsp.rdata[STAT_MODE_LSB +: 3]     <= activeMode;
                  axiRsp.rdata[STAT_PHASE_LSB +: 3]    <= phase;
                  axiRsp.rdata[STAT_REFVALID_LSB +: 5] <= refValid;
                  axiRsp.rdata[STAT_HISTVALID]         <= histValid;
                  axiRsp.rdata[STAT_SELECT_LSB +: 3]   <= selS2;
               end
               REG_TUNE:    axiRsp.rdata <= tune;
               REG_HISTORY: axiRsp.rdata <= history;
               REG_NOMINAL: axiRsp.rdata <= nominal;
               default:     axiRsp.rresp <= RESP_SLVERR;
            endcase
         end else if (axiRsp.rvalid && axiReq.rready) begin
            axiRsp.rvalid  <= 1'b0;
            axiRsp.arready <= 1'b1;
         end else if (!axiRsp.rvalid) begin
            axiRsp.arready <= 1'b1;
         end
      end
   end

endmodule

// ==== design/tms_pkg.sv ====
// shared constants and types of the timing mode selector
package tms_pkg;

   localparam int AXI_ADDR_W = 8;
   localparam int AXI_DATA_W = 32;

   typedef struct packed {
      logic                    awvalid;
      logic [AXI_ADDR_W-1:0]   awaddr;
      logic                    wvalid;
      logic [AXI_DATA_W-1:0]   wdata;
      logic [3:0]              wstrb;
      logic                    bready;
      logic                    arvalid;
      logic [AXI_ADDR_W-1:0]   araddr;
      logic                    rready;
   } tms_axi_req_t;

   typedef struct packed {
      logic                    awready;
      logic                    wready;
      logic                    bvalid;
      logic [1:0]              bresp;
      logic                    arready;
      logic                    rvalid;
      logic [AXI_DATA_W-1:0]   rdata;
      logic [1:0]              rresp;
   } tms_axi_rsp_t;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // register byte offsets
   localparam logic [AXI_ADDR_W-1:0] REG_CTRL    = 8'h00;
   localparam logic [AXI_ADDR_W-1:0] REG_STATUS  = 8'h04;
   localparam logic [AXI_ADDR_W-1:0] REG_TUNE    = 8'h08;
   localparam logic [AXI_ADDR_W-1:0] REG_HISTORY = 8'h0c;
   localparam logic [AXI_ADDR_W-1:0] REG_NOMINAL = 8'h10;

   // field positions
   localparam int CTRL_DIV_LSB      = 0;
   localparam int STAT_MODE_LSB     = 0;
   localparam int STAT_PHASE_LSB    = 4;
   localparam int STAT_REFVALID_LSB = 8;
   localparam int STAT_HISTVALID    = 13;
   localparam int STAT_SELECT_LSB   = 16;

   // reset values
   localparam logic [1:0]  CTRL_DIV_RST     = 2'h0;
   localparam logic [31:0] NOMINAL_TUNE_RST = 32'h2000_0000;

   // mode codes, third select line is the msb
   localparam logic [2:0] MODE_FREE    = 3'h0;
   localparam logic [2:0] MODE_REF1    = 3'h1;
   localparam logic [2:0] MODE_REF5    = 3'h5;
   localparam logic [2:0] MODE_IGNORED = 3'h6;
   localparam logic [2:0] MODE_HOLD    = 3'h7;

   typedef enum logic [2:0] {
      PH_IDLE,
      PH_EVAL,
      PH_ACQ,
      PH_PHASE,
      PH_LOCKED
   } tms_phase_t;

   // timing
   localparam int CLK_PERIOD_NS       = 50;
   localparam int EVAL_TIME_US        = 100;
   localparam int ACQ_WINDOW_US       = 50;
   localparam int REF_TIMEOUT_US      = 200;
   localparam int EVAL_CYCLES         = (EVAL_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ACQ_CYCLES          = (ACQ_WINDOW_US * 1000) / CLK_PERIOD_NS;
   localparam int REF_TIMEOUT_CYCLES  = (REF_TIMEOUT_US * 1000) / CLK_PERIOD_NS;
   localparam int MODE_STABLE_SAMPLES = 4;
   localparam int LOCK_EDGES          = 8;
   localparam int REF_MIN_PERIOD      = 2;

endpackage

// ==== design/tms_ref_monitor.sv ====
// activity and period monitor for one reference input
`timescale 1ns/1ns
module tms_ref_monitor #(
   parameter int CNT_W   = 13,
   parameter int TIMEOUT = tms_pkg::REF_TIMEOUT_CYCLES,
   parameter int MIN_PER = tms_pkg::REF_MIN_PERIOD
)(
   input  wire logic             clk,
   input  wire logic             sys_rst,
   input  wire logic             ce,
   input  wire logic             refIn,
   output logic                  refEdge,
   output logic                  refValid,
   output logic [CNT_W-1:0]      refPeriod
);
   import tms_pkg::*;

   logic             refS1;
   logic             refS2;
   logic             refS3;
   logic [CNT_W-1:0] gapCnt;
   logic             seenOne;
   logic             rise;

   assign rise = refS2 & ~refS3;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         refS1 <= 1'b0;
         refS2 <= 1'b0;
         refS3 <= 1'b0;
      end else if (ce) begin
         refS1 <= refIn;
         refS2 <= refS1;
         refS3 <= refS2;
      end
   end

   // edge spacing check, runs whatever mode is active
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         gapCnt    <= '0;
         seenOne   <= 1'b0;
         refValid  <= 1'b0;
         refEdge   <= 1'b0;
         refPeriod <= '0;
      end else if (ce) begin
         refEdge <= rise;
         if (rise) begin
            refPeriod <= gapCnt;
            gapCnt    <= '0;
            seenOne   <= 1'b1;
            refValid  <= seenOne && (gapCnt >= CNT_W'(MIN_PER)) && (gapCnt < CNT_W'(TIMEOUT));
         end else if (gapCnt >= CNT_W'(TIMEOUT)) begin
            refValid <= 1'b0;
            seenOne  <= 1'b0;
         end else begin
            gapCnt <= gapCnt + 1'b1;
         end
      end
   end

endmodule

// ==== verif/tms_host_model.sv ====
// host side model: drives the select pins and five reference clocks
`timescale 1ns/1ns
module tms_host_model (
   input  wire logic       clk,
   input  wire logic [2:0] code,
   input  wire logic [4:0] refOn,
   output logic [2:0]      sel,
   output logic [4:0]      refOut
);
   logic [2:0] cnt = 3'h0;

   // sel[2] is the third select line, the msb of the code
   assign sel = code;

   always @(posedge clk) begin
      cnt <= cnt + 3'h1;
   end

   // period of eight clocks, each reference on its own phase; a removed one rests low
   for (genvar i = 0; i < 5; i++) begin : g_ref
      assign refOut[i] = refOn[i] && (3'(cnt + 3'(i)) >= 3'h4);
   end
endmodule

// ==== verif/tms_timing_mode_selector_asserts.sv ====
// port level checks of the timing mode selector
`timescale 1ns/1ns
module tms_asserts (
   input wire logic                  clk,
   input wire logic                  sys_rst,
   input wire logic                  ce,
   input wire tms_pkg::tms_axi_req_t axiReq,
   input wire tms_pkg::tms_axi_rsp_t axiRsp,
   input wire logic                  primaryOutputEnable,
   input wire logic                  secondaryOutputEnable,
   input wire logic                  dividedOutputEnable,
   input wire logic                  hfClockPrimary,
   input wire logic                  hfClockSecondary,
   input wire logic                  hfClockDivided
);
   import tms_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);

   a_primary_gated: assert property (
      (ce && !primaryOutputEnable)[*5] |-> !hfClockPrimary) else $error("primary on while disabled");
   a_divided_gated: assert property (
      (ce && !dividedOutputEnable)[*5] |-> !hfClockDivided) else $error("divided on while disabled");
   a_secondary_copy: assert property (
      (ce && primaryOutputEnable && secondaryOutputEnable)[*5] |-> hfClockSecondary == hfClockPrimary)
      else $error("secondary differs from primary");
   a_divided_follows: assert property (
      (ce && primaryOutputEnable && dividedOutputEnable)[*6] ##0 $rose(hfClockDivided) |-> ##[0:1] hfClockPrimary)
      else $error("divided rise away from primary");
   a_write_answer: assert property (
      ce && axiReq.awvalid && axiRsp.awready && axiReq.wvalid && axiRsp.wready ##1 ce |=> axiRsp.bvalid)
      else $error("write response late");
   a_read_answer: assert property (
      ce && axiReq.arvalid && axiRsp.arready |=> axiRsp.rvalid) else $error("read data late");
   a_read_hold: assert property (
      axiRsp.rvalid && !axiReq.rready |=> axiRsp.rvalid && $stable(axiRsp.rdata)) else $error("read data dropped");
   a_unmapped_read: assert property (
      ce && axiReq.arvalid && axiRsp.arready && axiReq.araddr > 8'h13 |=> axiRsp.rresp == RESP_SLVERR
      && axiRsp.rdata == 32'h0) else $error("unmapped read not refused");
   a_ce_freeze: assert property (
      !ce |=> $stable(hfClockPrimary) && $stable(axiRsp)) else $error("state moved with ce low");
endmodule

bind tms_timing_mode_selector tms_asserts u_asserts (
   .clk, .sys_rst, .ce, .axiReq, .axiRsp, .primaryOutputEnable, .secondaryOutputEnable,
   .dividedOutputEnable, .hfClockPrimary, .hfClockSecondary, .hfClockDivided
);

// ==== verif/tms_timing_mode_selector_tb.sv ====
// self-checking bench of the timing mode selector
`timescale 1ns/1ns
module tms_timing_mode_selector_tb;
   import tms_pkg::*;
   typedef struct packed {
      logic [2:0] code;
      logic [2:0] mode;
      logic [2:0] phase;
   } tms_row_t;
   // select code beside the mode and phase it should give
   localparam tms_row_t ROWS [8] = '{9'h000, 9'h049, 9'h091, 9'h0d9, 9'h121, 9'h169, 9'h1a9, 9'h1f8};
   logic         clk = 1'b0;
   logic         sys_rst;
   logic         ce;
   tms_axi_req_t axiReq;
   tms_axi_rsp_t axiRsp;
   logic [2:0]   code;
   logic [2:0]   sel;
   logic [4:0]   refOn;
   logic [4:0]   refs;
   logic [2:0]   outEn;
   logic [2:0]   hf;
   int           mismatches = 0;
   int           comparisons = 0;
   int           cycles = 0;

   tms_host_model u_host (.clk, .code, .refOn, .sel, .refOut(refs));
   tms_timing_mode_selector u_dut (
      .clk, .sys_rst, .ce, .axiReq, .axiRsp,
      .modeSelectBit0(sel[0]), .modeSelectBit1(sel[1]), .modeSelectBit2(sel[2]),
      .referenceInput1(refs[0]), .referenceInput2(refs[1]), .referenceInput3(refs[2]),
      .referenceInput4(refs[3]), .referenceInput5(refs[4]),
      .primaryOutputEnable(outEn[0]), .secondaryOutputEnable(outEn[1]), .dividedOutputEnable(outEn[2]),
      .hfClockPrimary(hf[0]), .hfClockSecondary(hf[1]), .hfClockDivided(hf[2])
   );

   always #25 clk = ~clk;

   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 80000) begin
         mismatches++;
         end_sim();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chkResp(input logic [1:0] got, input logic [1:0] exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: response %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      axiReq.awaddr <= a;
      axiReq.wdata <= d;
      axiReq.wstrb <= 4'hf;
      axiReq.awvalid <= 1'b1;
      axiReq.wvalid <= 1'b1;
      do begin
         @(posedge clk);
         if (axiRsp.awready) axiReq.awvalid <= 1'b0;
         if (axiRsp.wready) axiReq.wvalid <= 1'b0;
      end while (!axiRsp.bvalid);
      r = axiRsp.bresp;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      axiReq.araddr <= a;
      axiReq.arvalid <= 1'b1;
      do begin
         @(posedge clk);
         if (axiRsp.arready) axiReq.arvalid <= 1'b0;
      end while (!axiRsp.rvalid);
      d = axiRsp.rdata;
      r = axiRsp.rresp;
   endtask

   task automatic rises(input int n, output int rc [3]);
      logic [2:0] pv;
      rc = '{0, 0, 0};
      pv = hf;
      repeat (n) begin
         @(posedge clk);
         for (int k = 0; k < 3; k++) begin
            if (hf[k] && !pv[k]) rc[k]++;
         end
         pv = hf;
      end
   endtask

   initial begin
      logic [31:0] v;
      logic [31:0] h;
      logic [1:0]  r;
      logic [2:0]  last;
      logic [2:0]  pv;
      int          rc [3];
      int          p;
      int          cnt;
      ce = 1'b1;
      code = 3'h0;
      refOn = 5'h0f;
      outEn = 3'h7;
      axiReq = '0;
      // answers are always taken at once
      axiReq.bready = 1'b1;
      axiReq.rready = 1'b1;
      sys_rst = 1'b1;
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      rd(REG_CTRL, v, r);
      chk(v, 32'(CTRL_DIV_RST));
      rd(REG_NOMINAL, v, r);
      chk(v, NOMINAL_TUNE_RST);
      rd(REG_TUNE, v, r);
      chk(v, NOMINAL_TUNE_RST);
      wr(8'h40, 32'h5, r);
      chkResp(r, RESP_SLVERR);
      rd(8'h40, v, r);
      chkResp(r, RESP_SLVERR);
      $display("test reset and bus done");
      for (int i = 0; i < 8; i++) begin
         code <= ROWS[i].code;
         repeat (30) @(posedge clk);
         rd(REG_STATUS, v, r);
         chk(v & 32'h73f77, {13'h0, ROWS[i].code, 3'h0, 5'h0f, 1'h0, ROWS[i].phase, 1'h0, ROWS[i].mode});
      end
      $display("test mode rows done");
      code <= 3'h0;
      repeat (30) @(posedge clk);
      code <= 3'h2;
      repeat (2) @(posedge clk);
      // ignored code after the blip keeps whatever mode was taken
      code <= 3'h6;
      repeat (30) @(posedge clk);
      rd(REG_STATUS, v, r);
      chk(v & 32'h77, 32'h0);
      $display("test select blip done");
      for (int d = 0; d < 4; d++) begin
         wr(REG_CTRL, 32'(d), r);
         repeat (40) @(posedge clk);
         p = 0;
         cnt = 0;
         pv = hf;
         while (p < 2) begin
            @(posedge clk);
            if (hf[0] && !pv[0] && p == 1) cnt++;
            if (hf[2] && !pv[2]) p++;
            pv = hf;
         end
         chk(32'(cnt), 32'(1 << d));
      end
      rd(REG_CTRL, v, r);
      chk(v, 32'h3);
      wr(REG_CTRL, 32'h0, r);
      $display("test divider done");
      for (int i = 0; i < 3; i++) begin
         outEn <= ~(3'h1 << i);
         repeat (10) @(posedge clk);
         rises(32, rc);
         for (int k = 0; k < 3; k++) begin
            chk(32'(rc[k]), (k == i) ? 32'h0 : 32'h4);
         end
      end
      outEn <= 3'h7;
      ce <= 1'b0;
      repeat (4) @(posedge clk);
      rises(16, rc);
      chk(32'(rc[0]), 32'h0);
      ce <= 1'b1;
      $display("test enables done");
      // only the third reference runs while locking to it
      refOn <= 5'h04;
      code <= 3'h3;
      last = 3'h0;
      do begin
         rd(REG_STATUS, v, r);
         if (v[6:4] !== last) begin
            chk(32'(v[6:4]), 32'(last + 3'h1));
            last = v[6:4];
         end
      end while (v[6:4] !== 3'h4);
      // removed references must have timed out by now
      repeat (REF_TIMEOUT_CYCLES) @(posedge clk);
      rd(REG_STATUS, v, r);
      chk(v & 32'h3f00, 32'h2400);
      code <= 3'h7;
      repeat (30) @(posedge clk);
      rd(REG_HISTORY, h, r);
      rd(REG_TUNE, v, r);
      chk(v, h);
      repeat (200) @(posedge clk);
      rd(REG_HISTORY, v, r);
      chk(v, h);
      code <= 3'h0;
      repeat (30) @(posedge clk);
      rd(REG_TUNE, v, r);
      chk(v, NOMINAL_TUNE_RST);
      wr(REG_NOMINAL, 32'h1000_0000, r);
      rd(REG_TUNE, v, r);
      chk(v, 32'h1000_0000);
      rd(REG_HISTORY, v, r);
      chk(v, h);
      $display("test lock and holdover done");
      end_sim();
   end
endmodule
